// File: core/irq_priority_select.sv
`timescale 1ns/10ps
module irq_priority_select
  import uart_fmt_pkg::*;
#(
  parameter int SOURCES = NUM_SRC
) (
  irq_sel_if.selector sel // Pending sources in, winning source out.
);

  // The code table below is fixed, so any other source count is refused at elaboration.
  if (SOURCES != NUM_SRC) begin : g_bad_sources
    $error("irq_priority_select serves exactly the seven defined sources");
  end

  // Fixed code per source index.
  function automatic logic [5:0] code_of(input logic [2:0] idx);
    logic [5:0] c;
    c = CODE_MODEM;
    unique case (idx)
      3'h0: c = CODE_LINE;
      3'h1: c = CODE_RXDATA;
      3'h2: c = CODE_RXTIMEOUT;
      3'h3: c = CODE_TXEMPTY;
      3'h4: c = CODE_MODEM;
      3'h5: c = CODE_XOFF;
      3'h6: c = CODE_FLOWCHG;
      default: c = CODE_MODEM;
    endcase
    return c;
  endfunction

  // Scan from the lowest priority up, so the highest pending one is left standing.
  always_comb begin
    sel.found = 1'b0;
    sel.index = 3'h0;
    for (int i = SOURCES - 1; i >= 0; i--) begin
      if (sel.pending[i]) begin
        sel.found = 1'b1;
        sel.index = 3'(i);
      end
    end
    sel.code = code_of(sel.index);
  end

endmodule

// File: core/irq_sel_if.sv
`timescale 1ns/10ps
interface irq_sel_if;
  import uart_fmt_pkg::*;
  logic [NUM_SRC-1:0] pending;
  logic               found;
  logic [2:0]         index;
  logic [5:0]         code;
  modport requester (output pending, input found, input index, input code);
  modport selector  (input pending, output found, output index, output code);
endinterface

// File: core/uart_fmt_pkg.sv
package uart_fmt_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_FORMAT    = 8'h04;
  localparam logic [7:0] OFF_FEATURE   = 8'h08;
  localparam logic [7:0] OFF_FIFO_MODE = 8'h0C;
  localparam logic [7:0] OFF_EVENT     = 8'h10;
  localparam logic [7:0] OFF_MASK      = 8'h14;

  // Reset values.
  localparam logic [7:0] FORMAT_RESET  = 8'h00;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [6:0] EVENT_RESET   = 7'h00;
  localparam logic [6:0] MASK_RESET    = 7'h00;

  // Field positions of the line format control byte.
  localparam int FMT_DIVISOR_BIT = 7;
  localparam int FMT_BREAK_BIT   = 6;
  localparam int FMT_PARITY_MSB  = 5;
  localparam int FMT_PARITY_LSB  = 3;
  localparam int FMT_STOP_BIT    = 2;
  localparam int FMT_LEN_MSB     = 1;

  // Field positions of the enhanced feature control and FIFO mode bytes.
  localparam int FEAT_FLOW_IRQ_BIT = 4;
  localparam int FIFO_ENABLE_BIT   = 0;

  // Interrupt sources, index 0 is the highest priority.
  localparam int NUM_SRC       = 7;
  localparam int SRC_LINE      = 0;
  localparam int SRC_RXDATA    = 1;
  localparam int SRC_RXTIMEOUT = 2;
  localparam int SRC_TXEMPTY   = 3;
  localparam int SRC_MODEM     = 4;
  localparam int SRC_XOFF      = 5;
  localparam int SRC_FLOWCHG   = 6;

  // Interrupt codes shown in status bits 5 down to 0.
  localparam logic [5:0] CODE_LINE      = 6'h06;
  localparam logic [5:0] CODE_RXDATA    = 6'h04;
  localparam logic [5:0] CODE_RXTIMEOUT = 6'h0C;
  localparam logic [5:0] CODE_TXEMPTY   = 6'h02;
  localparam logic [5:0] CODE_MODEM     = 6'h00;
  localparam logic [5:0] CODE_XOFF      = 6'h10;
  localparam logic [5:0] CODE_FLOWCHG   = 6'h20;

  // Word length and stop length figures.
  localparam logic [3:0] WORD_BITS_BASE = 4'h5;
  localparam logic [2:0] STOP_HALF_ONE  = 3'h2;
  localparam logic [2:0] STOP_HALF_1P5  = 3'h3;
  localparam logic [2:0] STOP_HALF_TWO  = 3'h4;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PAR_NONE = 3'h0,
    PAR_ODD  = 3'h1,
    PAR_EVEN = 3'h2,
    PAR_ONE  = 3'h3,
    PAR_ZERO = 3'h4
  } parity_t;

endpackage

// File: core/uart_irq_format.sv
// What this block does
// - Status read returns code of the reported source, picked as highest pending among six levels.
// - Reported source stays reported until serviced; nothing replaces it.
// - After servicing, a re-read shows the highest level still pending.
// - Line condition is level 1, code 000110.
// - Lower sources use codes 000100, 001100, 000010, 000000, 010000.
// - CTS or RTS change is level 6, code 100000.
// - Status bits 5 and 4 report only with enhanced bit 4 set.
// - Xoff match sets bit 4; it stays until Xon arrives.
// - Status bits 2 to 0 identify levels 1, 2 and 3.
// - Status bits 7 and 6 read one with FIFOs enabled, else zero.
// - Status bit 0 is zero while pending, one when idle and at reset.
// - Format bit 7 grants access to divisor latch and enhanced registers.
// - Format bit 6 holds serial output low as break until cleared.
// - Format bits 5 to 3 select none, odd, even, forced one, forced zero.
// - Format bit 2 clear gives one stop, else 1.5 for 5-bit, 2 otherwise.
// - Format bits 1 and 0 select word length 5, 6, 7 or 8.
`timescale 1ns/10ps
module uart_irq_format
  import uart_fmt_pkg::*;
(
  input  wire logic        aclk,                // System clock, 40 MHz.
  input  wire logic        aresetn,             // Synchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,        // Write address.
  input  wire logic [2:0]  s_axi_awprot,        // Unused protection.
  input  wire logic        s_axi_awvalid,       // Write address valid.
  output logic             s_axi_awready,       // Write address ready.
  input  wire logic [31:0] s_axi_wdata,         // Write data.
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte enables.
  input  wire logic        s_axi_wvalid,        // Write data valid.
  output logic             s_axi_wready,        // Write data ready.
  output logic [1:0]       s_axi_bresp,         // Write response.
  output logic             s_axi_bvalid,        // Write response valid.
  input  wire logic        s_axi_bready,        // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,        // Read address.
  input  wire logic [2:0]  s_axi_arprot,        // Unused protection.
  input  wire logic        s_axi_arvalid,       // Read address valid.
  output logic             s_axi_arready,       // Read address ready.
  output logic [31:0]      s_axi_rdata,         // Read data.
  output logic [1:0]       s_axi_rresp,         // Read response.
  output logic             s_axi_rvalid,        // Read data valid.
  input  wire logic        s_axi_rready,        // Read data ready.
  input  wire logic        line_condition_report, // Receiver line status pending.
  input  wire logic        receive_data_event,  // Received data ready.
  input  wire logic        receive_timeout,     // Receive data time-out.
  input  wire logic        transmit_holding_empty_event, // Holding register empty.
  input  wire logic        modem_change_report, // Modem status change pending.
  input  wire logic        xoff_match,          // Pulse: matching Xoff or special seen.
  input  wire logic        xon_match,           // Pulse: matching Xon received.
  input  wire logic        flow_line_change,    // CTS or RTS change pending.
  output logic             divisor_access,      // Divisor and enhanced access open.
  output logic             tx_break,            // Hold serial output low.
  output logic [3:0]       word_bits,           // Character length in bits.
  output logic [2:0]       stop_half_bits,      // Stop length in half bit times.
  output parity_t          parity_mode,         // Parity selection.
  output logic             irq                  // Level interrupt.
);

  typedef struct packed {
    logic               aw_ready;
    logic               aw_have;
    logic [7:0]         aw_addr;
    logic               w_ready;
    logic               w_have;
    logic [7:0]         w_byte;
    logic               w_lane0;
    logic               b_valid;
    logic [1:0]         b_resp;
    logic               ar_ready;
    logic               r_valid;
    logic [31:0]        r_data;
    logic [1:0]         r_resp;
    logic [7:0]         format;
    logic [7:0]         feature;
    logic               fifo_on;
    logic [NUM_SRC-1:0] event_flags;
    logic [NUM_SRC-1:0] event_mask;
    logic [NUM_SRC-1:0] prev_pending;
    logic               xoff_flag;
    logic               held_valid;
    logic [2:0]         held_index;
    logic [5:0]         held_code;
    logic               tx_break;
    logic               divisor_access;
    logic [3:0]         word_bits;
    logic [2:0]         stop_half_bits;
    parity_t            parity_mode;
    logic               irq;
  } state_t;

  state_t st;
  state_t next_st;

  irq_sel_if sel_bus ();

  logic [NUM_SRC-1:0] pending;
  logic [7:0]         status_byte;

  irq_priority_select #(
    .SOURCES (NUM_SRC)
  ) u_select (
    .sel (sel_bus.selector)
  );

  // Flow-related sources only exist while the enhanced feature bit is set.
  always_comb begin
    pending                = '0;
    pending[SRC_LINE]      = line_condition_report;
    pending[SRC_RXDATA]    = receive_data_event;
    pending[SRC_RXTIMEOUT] = receive_timeout;
    pending[SRC_TXEMPTY]   = transmit_holding_empty_event;
    pending[SRC_MODEM]     = modem_change_report;
    pending[SRC_XOFF]      = st.xoff_flag && st.feature[FEAT_FLOW_IRQ_BIT];
    pending[SRC_FLOWCHG]   = flow_line_change && st.feature[FEAT_FLOW_IRQ_BIT];
  end

  assign sel_bus.pending = pending;

  // Status byte as the host reads it; the low code bit always reads the idle flag.
  always_comb begin
    status_byte      = 8'h00;
    status_byte[7:6] = {2{st.fifo_on}};
    status_byte[5:1] = st.held_valid ? st.held_code[5:1] : 5'h00;
    status_byte[0]   = !st.held_valid;
  end

  // Format field decode; 001 is taken as forced one since its row is more specific.
  function automatic parity_t decode_parity(input logic [2:0] f);
    parity_t p;
    p = PAR_NONE;
    if (!f[0]) begin
      p = PAR_NONE;
    end else if (f == 3'h1) begin
      p = PAR_ONE;
    end else if (!f[1]) begin
      p = PAR_ODD;
    end else if (!f[2]) begin
      p = PAR_EVEN;
    end else begin
      p = PAR_ZERO;
    end
    return p;
  endfunction

  // Next-state logic for the bus slave, registers and interrupt tracking.
  always_comb begin
    logic [NUM_SRC-1:0] clear_bits;
    logic               do_write;
    logic               wr_ok;
    clear_bits = '0;
    do_write   = 1'b0;
    wr_ok      = 1'b0;
    next_st    = st;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && st.aw_ready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_ready) begin
      next_st.w_have  = 1'b1;
      next_st.w_byte  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st.b_valid && s_axi_bready) begin
      next_st.b_valid = 1'b0;
    end

    // Perform the write once both halves are held and no response is outstanding.
    if (st.aw_have && st.w_have && !st.b_valid) begin
      do_write        = 1'b1;
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.b_valid = 1'b1;
      wr_ok           = 1'b1;
      unique case (st.aw_addr)
        OFF_FORMAT: begin
          if (st.w_lane0) begin
            next_st.format = st.w_byte;
          end
        end
        OFF_FEATURE: begin
          // Enhanced registers are writable only while the access bit is set.
          if (st.w_lane0 && st.format[FMT_DIVISOR_BIT]) begin
            next_st.feature = st.w_byte;
          end
        end
        OFF_FIFO_MODE: begin
          if (st.w_lane0) begin
            next_st.fifo_on = st.w_byte[FIFO_ENABLE_BIT];
          end
        end
        OFF_EVENT: begin
          if (st.w_lane0) begin
            clear_bits = st.w_byte[NUM_SRC-1:0];
          end
        end
        OFF_MASK: begin
          if (st.w_lane0) begin
            next_st.event_mask = st.w_byte[NUM_SRC-1:0];
          end
        end
        OFF_STATUS: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      next_st.b_resp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.aw_ready = !next_st.aw_have && !(do_write || st.b_valid) && !next_st.b_valid;
    next_st.w_ready  = !next_st.w_have && !next_st.b_valid;

    // Reads answer one cycle after the address is taken; reading has no side effect.
    if (st.r_valid && s_axi_rready) begin
      next_st.r_valid = 1'b0;
    end
    if (s_axi_arvalid && st.ar_ready) begin
      next_st.r_valid = 1'b1;
      next_st.r_resp  = RESP_OKAY;
      next_st.r_data  = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_STATUS:    next_st.r_data[7:0] = status_byte;
        OFF_FORMAT:    next_st.r_data[7:0] = st.format;
        OFF_FEATURE: begin
          if (st.format[FMT_DIVISOR_BIT]) begin
            next_st.r_data[7:0] = st.feature;
          end
        end
        OFF_FIFO_MODE: next_st.r_data[FIFO_ENABLE_BIT] = st.fifo_on;
        OFF_EVENT:     next_st.r_data[NUM_SRC-1:0] = st.event_flags;
        OFF_MASK:      next_st.r_data[NUM_SRC-1:0] = st.event_mask;
        default:       next_st.r_resp = RESP_SLVERR;
      endcase
    end
    next_st.ar_ready = !next_st.r_valid;

    // Xoff flag: a match sets it and only an Xon match clears it; set wins.
    if (xon_match) begin
      next_st.xoff_flag = 1'b0;
    end
    if (xoff_match) begin
      next_st.xoff_flag = 1'b1;
    end

    // Keep the reported source while it is still pending; re-pick only once serviced.
    if (st.held_valid && pending[st.held_index]) begin
      next_st.held_valid = 1'b1;
    end else if (sel_bus.found) begin
      next_st.held_valid = 1'b1;
      next_st.held_index = sel_bus.index;
      next_st.held_code  = sel_bus.code;
    end else begin
      next_st.held_valid = 1'b0;
    end

    // Sticky event bits on a source becoming pending; a new event beats the clear.
    next_st.prev_pending = pending;
    next_st.event_flags  = (st.event_flags & ~clear_bits) | (pending & ~st.prev_pending);
    next_st.irq          = |(next_st.event_flags & next_st.event_mask);

    // Line format outputs, registered from the next format byte.
    next_st.divisor_access = next_st.format[FMT_DIVISOR_BIT];
    next_st.tx_break       = next_st.format[FMT_BREAK_BIT];
    next_st.word_bits      = WORD_BITS_BASE + {2'b00, next_st.format[FMT_LEN_MSB:0]};
    if (!next_st.format[FMT_STOP_BIT]) begin
      next_st.stop_half_bits = STOP_HALF_ONE;
    end else if (next_st.format[FMT_LEN_MSB:0] == 2'b00) begin
      next_st.stop_half_bits = STOP_HALF_1P5;
    end else begin
      next_st.stop_half_bits = STOP_HALF_TWO;
    end
    next_st.parity_mode = decode_parity(next_st.format[FMT_PARITY_MSB:FMT_PARITY_LSB]);
  end

  // Single state register; every output below is a field of it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                <= '0;
      st.format         <= FORMAT_RESET;
      st.feature        <= FEATURE_RESET;
      st.event_flags    <= EVENT_RESET;
      st.event_mask     <= MASK_RESET;
      st.b_resp         <= RESP_OKAY;
      st.r_resp         <= RESP_OKAY;
      st.aw_ready       <= 1'b1;
      st.w_ready        <= 1'b1;
      st.ar_ready       <= 1'b1;
      st.word_bits      <= WORD_BITS_BASE;
      st.stop_half_bits <= STOP_HALF_ONE;
      st.parity_mode    <= PAR_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready  = st.aw_ready;
  assign s_axi_wready   = st.w_ready;
  assign s_axi_bresp    = st.b_resp;
  assign s_axi_bvalid   = st.b_valid;
  assign s_axi_arready  = st.ar_ready;
  assign s_axi_rdata    = st.r_data;
  assign s_axi_rresp    = st.r_resp;
  assign s_axi_rvalid   = st.r_valid;
  assign divisor_access = st.divisor_access;
  assign tx_break       = st.tx_break;
  assign word_bits      = st.word_bits;
  assign stop_half_bits = st.stop_half_bits;
  assign parity_mode    = st.parity_mode;
  assign irq            = st.irq;

endmodule

// File: testbench/event_source_model.sv
`timescale 1ns/10ps
module event_source_model (
  input  wire logic       aclk,   // System clock.
  input  wire logic [8:0] cmd,    // Levels 6..0, then Xoff and Xon requests.
  output logic [6:0]      level,  // Pending source levels.
  output logic            xoff_p, // One-cycle Xoff match.
  output logic            xon_p   // One-cycle Xon match.
);
  // A serviced source drops its level; the block has no other way to learn of it.
  always_ff @(posedge aclk) begin
    level <= cmd[6:0];
    xoff_p <= cmd[7];
    xon_p <= cmd[8];
  end
endmodule

// File: testbench/irq_format_chk.sv
`timescale 1ns/10ps
module irq_format_chk
  import uart_fmt_pkg::*;
(
  input wire logic        aclk,           // Clock.
  input wire logic        aresetn,        // Reset, active low.
  input wire logic [7:0]  s_axi_awaddr,   // Write address.
  input wire logic        s_axi_awvalid,  // Write address valid.
  input wire logic        s_axi_awready,  // Write address ready.
  input wire logic [31:0] s_axi_wdata,    // Write data.
  input wire logic [3:0]  s_axi_wstrb,    // Byte enables.
  input wire logic        s_axi_wvalid,   // Write data valid.
  input wire logic        s_axi_wready,   // Write data ready.
  input wire logic        s_axi_bvalid,   // Write response valid.
  input wire logic [7:0]  s_axi_araddr,   // Read address.
  input wire logic        s_axi_arvalid,  // Read address valid.
  input wire logic        s_axi_arready,  // Read address ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic [1:0]  s_axi_rresp,    // Read response.
  input wire logic        s_axi_rvalid,   // Read data valid.
  input wire logic        s_axi_rready,   // Read data ready.
  input wire logic        divisor_access, // Divisor access open.
  input wire logic        tx_break,       // Break output.
  input wire logic [3:0]  word_bits,      // Word length.
  input wire logic [2:0]  stop_half_bits, // Stop length.
  input wire logic        irq             // Interrupt.
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic fmt_take;
  // Write taken on one edge: the register lands one edge later, seen the edge after.
  assign fmt_take = s_axi_awvalid && s_axi_awready && s_axi_awaddr == OFF_FORMAT
                    && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  rst_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !irq && !divisor_access && !tx_break) else $error("bad reset state");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFF_MASK
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  status_form_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFF_STATUS |=> s_axi_rdata[31:8] == 24'h0
    && s_axi_rdata[7] == s_axi_rdata[6] && (!s_axi_rdata[0] || s_axi_rdata[5:1] == 5'h0)
    && (s_axi_rdata[5:4] == 2'h0 || s_axi_rdata[3:0] == 4'h0)) else $error("status form");
  stop_half_a: assert property (stop_half_bits == STOP_HALF_1P5 |-> word_bits == 4'h5)
    else $error("1.5 stop with long word");
  stop_two_a: assert property (stop_half_bits == STOP_HALF_TWO |-> word_bits != 4'h5)
    else $error("2 stop with 5-bit word");
  len_range_a: assert property (word_bits inside {[4'h5:4'h8]})
    else $error("word length out of range");
  fmt_write_a: assert property (fmt_take |=> ##1 tx_break == $past(s_axi_wdata[6], 2)
    && divisor_access == $past(s_axi_wdata[7], 2) && s_axi_bvalid) else $error("format write");
  wr_cov: cover property (fmt_take);
  rd_cov: cover property (s_axi_rvalid && s_axi_rready);
  irq_cov: cover property ($rose(irq));
endmodule
bind uart_irq_format irq_format_chk irq_format_chk_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .divisor_access, .tx_break, .word_bits, .stop_half_bits, .irq);

// File: testbench/uart_irq_format_tb.sv
`timescale 1ns/10ps
module uart_irq_format_tb;
  import uart_fmt_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, tx_break, divisor_access, xoff_p, xon_p;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  word_bits;
  logic [2:0]  stop_half_bits;
  parity_t     parity_mode;
  logic [8:0]  cmd;
  logic [6:0]  level;
  int          bad_count, samples_checked, i;
  logic [2:0]  pc [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  parity_t     pe [5] = '{PAR_NONE, PAR_ONE, PAR_EVEN, PAR_ODD, PAR_ZERO};
  logic [8:0]  sv [4] = '{9'h01E, 9'h01C, 9'h018, 9'h010};
  logic [31:0] se [4] = '{32'h04, 32'h0C, 32'h02, 32'h00};

  uart_irq_format uart_irq_format_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_condition_report(level[0]),
    .receive_data_event(level[1]), .receive_timeout(level[2]),
    .transmit_holding_empty_event(level[3]), .modem_change_report(level[4]),
    .xoff_match(xoff_p), .xon_match(xon_p), .flow_line_change(level[6]), .divisor_access,
    .tx_break, .word_bits, .stop_half_bits, .parity_mode, .irq);
  event_source_model event_source_model_inst (.aclk, .cmd, .level, .xoff_p, .xon_p);

  // Free-running 40 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data go out together; each drops once taken, bready rises with them.
  // One edge passes after the response so bready is never driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    bad_count++;
    complete_run();
  endtask

  // Rready rises with the request, or only after rvalid is seen when late is set,
  // so that the slave must hold its answer for a stalled cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
                    input string nm, input bit late = 1'b0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !late;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        chk(nm, s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    bad_count++;
    complete_run();
  endtask

  // Pulse requests last one cycle; the wait covers the model and selection latency.
  task automatic src(input logic [8:0] v);
    cmd <= v;
    @(posedge aclk);
    cmd <= {2'b00, v[6:0]};
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_STATUS, 32'h01, RESP_OKAY, "status");
    chk("word_bits", 32'(word_bits), 32'h5);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(OFF_FORMAT, 32'h4 | i);
      chk("word_bits", 32'(word_bits), 32'(5 + i));
      chk("stop", 32'(stop_half_bits), (i == 0) ? 32'h3 : 32'h4);
    end
    wr(OFF_FORMAT, 32'h03);
    chk("stop", 32'(stop_half_bits), 32'h2);
    for (i = 0; i < 5; i++) begin
      wr(OFF_FORMAT, 32'(pc[i]) << 3);
      chk("parity", 32'(parity_mode), 32'(pe[i]));
    end
    wr(OFF_FORMAT, 32'h40);
    chk("tx_break", 32'(tx_break), 32'h1);
    rd(OFF_FORMAT, 32'h40, RESP_OKAY, "format", 1'b1);
    wr(OFF_FORMAT, 32'h00);
    chk("tx_break", 32'(tx_break), 32'h0);
    $display("test format done");
    src(9'h008);
    rd(OFF_EVENT, 32'h08, RESP_OKAY, "events");
    chk("irq", 32'(irq), 32'h0);
    wr(OFF_MASK, 32'h08);
    chk("irq", 32'(irq), 32'h1);
    wr(OFF_EVENT, 32'h08);
    chk("irq", 32'(irq), 32'h0);
    $display("test interrupt done");
    rd(OFF_STATUS, 32'h02, RESP_OKAY, "status");
    src(9'h009);
    rd(OFF_STATUS, 32'h02, RESP_OKAY, "status");
    src(9'h001);
    rd(OFF_STATUS, 32'h06, RESP_OKAY, "status");
    src(9'h01F);
    rd(OFF_STATUS, 32'h06, RESP_OKAY, "status");
    for (i = 0; i < 4; i++) begin
      src(sv[i]);
      rd(OFF_STATUS, se[i], RESP_OKAY, "status");
    end
    src(9'h040);
    rd(OFF_STATUS, 32'h01, RESP_OKAY, "status");
    wr(OFF_FEATURE, 32'h10);
    rd(OFF_FEATURE, 32'h00, RESP_OKAY, "feature");
    wr(OFF_FORMAT, 32'h80);
    chk("divisor", 32'(divisor_access), 32'h1);
    wr(OFF_FEATURE, 32'h10);
    rd(OFF_FEATURE, 32'h10, RESP_OKAY, "feature");
    rd(OFF_STATUS, 32'h20, RESP_OKAY, "status");
    src(9'h080);
    rd(OFF_STATUS, 32'h10, RESP_OKAY, "status");
    repeat (5) @(posedge aclk);
    rd(OFF_STATUS, 32'h10, RESP_OKAY, "status");
    src(9'h100);
    rd(OFF_STATUS, 32'h01, RESP_OKAY, "status");
    $display("test priority done");
    wr(OFF_FIFO_MODE, 32'h01);
    rd(OFF_STATUS, 32'hC1, RESP_OKAY, "status");
    rd(8'h20, 32'h0, RESP_SLVERR, "unmapped");
    $display("test map done");
    complete_run();
  end
endmodule
